// >>> health_status_pkg.sv
// Shared constants for the status pin routing and lock detect block
`default_nettype none
package health_status_pkg;
  // Register file geometry
  localparam int REG_COUNT = 21;
  localparam int REG_W = 16;
  localparam int ADDR_W = 5;
  // Register indices
  localparam logic [4:0] REG_CFG = 5'h00;
  localparam logic [4:0] REG_ROUTE = 5'h03;
  localparam logic [4:0] REG_INPUT = 5'h04;
  localparam logic [4:0] REG_STATUS = 5'h15;
  // Routing enables in the status_output_routing register
  localparam int ROUTE_A_SEL = 12;
  localparam int ROUTE_A_LOS = 11;
  localparam int ROUTE_A_UNL = 10;
  localparam int ROUTE_B_SEL = 9;
  localparam int ROUTE_B_LOS = 8;
  localparam int ROUTE_B_UNL = 7;
  localparam logic [15:0] ROUTE_RW_MASK = 16'h1f80;
  localparam logic [15:0] FULL_RW_MASK = 16'hffff;
  // Input control register fields
  localparam int IN_MAN_SEL_BIT = 0;
  localparam int IN_SMART_BIT = 1;
  localparam int IN_SEC_EN_BIT = 5;
  // Status register fields
  localparam int ST_SEL_BIT = 0;
  localparam int ST_LOS_BIT = 1;
  localparam int ST_UNLOCK_BIT = 2;
  localparam int CFG_W = 5;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Interface select strap codes
  localparam logic [1:0] SI_SPI = 2'b00;
  localparam logic [1:0] SI_I2C = 2'b01;
  localparam logic [1:0] SI_PIN = 2'b10;
  typedef enum logic [1:0] {MODE_SPI, MODE_I2C, MODE_PIN, MODE_NONE} if_mode_e;
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int LOS_TIME_NS = 400;
  localparam int LOS_CYCLES = (LOS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UNLOCK_HOLD_CYCLES = 1000;
  localparam int SLIP_LIMIT = 0;
endpackage
`default_nettype wire

// >>> slip_lock_detect.sv
// Digital cycle slip counter producing the PLL unlock flag
`timescale 1ns/100ps
`default_nettype none
module slip_lock_detect
  import health_status_pkg::*;
#(
  parameter int SLIP_MAX = SLIP_LIMIT,
  parameter int HOLD = UNLOCK_HOLD_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic ref_edge_in,
  input wire logic fb_edge_in,
  output logic unlock_out
);
  logic signed [2:0] phase;
  logic signed [2:0] next_phase;
  logic [7:0] slip_cnt;
  logic [10:0] hold_cnt;
  logic slip;
  logic trigger;

  // Phase difference between reference and feedback edges
  always_comb begin
    next_phase = phase + $signed({2'b00, ref_edge_in})
      - $signed({2'b00, fb_edge_in});
  end
  assign slip = (next_phase > 3'sd1) || (next_phase < -3'sd1); // RULE_08
  assign trigger = slip && (slip_cnt >= 8'(SLIP_MAX)); // RULE_08

  // A slip recentres the phase so the next one is caught too
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      phase <= 3'sd0;
    end else if (slip) begin
      phase <= 3'sd0; // RULE_08
    end else begin
      phase <= next_phase;
    end
  end

  // Slip counter resets once the limit is passed
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      slip_cnt <= 8'h00;
    end else if (trigger) begin
      slip_cnt <= 8'h00; // RULE_08
    end else if (slip) begin
      slip_cnt <= slip_cnt + 8'h01;
    end
  end

  // Unlock is stretched; steady slips keep it retriggered
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      hold_cnt <= 11'h000;
      unlock_out <= 1'b0;
    end else if (trigger) begin
      hold_cnt <= 11'(HOLD - 1); // RULE_09 RULE_10 RULE_11
      unlock_out <= 1'b1;
    end else if (hold_cnt != 11'h000) begin
      hold_cnt <= hold_cnt - 11'h001;
    end else begin
      unlock_out <= 1'b0;
    end
  end

  a_unlock_rise: assert property (@(posedge core_clk_in) // RULE_08
    disable iff (!rst_b_in) trigger |=> unlock_out [*8])
    else $error("unlock not raised after slip");
  a_unlock_fall: assert property (@(posedge core_clk_in) // RULE_11
    disable iff (!rst_b_in)
    (hold_cnt == 11'h001 && !trigger) ##1 !trigger |=> !unlock_out)
    else $error("unlock not released after hold");
  c_slip_seen: cover property (@(posedge core_clk_in) disable iff (!rst_b_in)
    trigger);
endmodule
`default_nettype wire

// >>> health_status_top.sv
// Status pin routing, reference health flags and register file
`timescale 1ns/100ps
`default_nettype none
// Contract
// RULE_01: Six route enables in register three bits 12:7
// RULE_02: Select flag: zero primary, one secondary
// RULE_03: Loss flag high when active reference lost
// RULE_04: Secondary enable clear forces loss flag high
// RULE_05: Unlock bit set; pin shows inverted lock
// RULE_06: Several enables on a pin are ORed
// RULE_07: Host enables one flag per used pin
// RULE_08: Count slips; flag unlock, reset counter
// RULE_09: Two percent error keeps unlock steady
// RULE_10: Half percent error toggles unlock indication
// RULE_11: One ppm error gives rare 1000-cycle drops
// RULE_12: Both references stalled: loss reads high
// RULE_13: Strap selects SPI, I2C or pin mode
// RULE_14: Pin mode takes config from five pins
// RULE_15: Twenty-one sixteen-bit registers, zero based
// RULE_16: Read-only bits ignore writes; RW bits store
// RULE_17: Flags registered on the update clock
module health_status_top
  import health_status_pkg::*;
#(
  parameter int LOS_LIMIT = LOS_CYCLES,
  parameter int HOLD = UNLOCK_HOLD_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic primary_reference_input_in,
  input wire logic secondary_reference_input_in,
  input wire logic fb_clk_in,
  input wire logic [1:0] si_mode_in,
  input wire logic [CFG_W-1:0] standalone_config_pins_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [REG_W-1:0] reg_wdata_in,
  output logic [REG_W-1:0] reg_rdata_out,
  output logic health_output_a_out,
  output logic health_output_b_out,
  output logic spi_en_out,
  output logic i2c_en_out,
  output logic [CFG_W-1:0] cfg_select_out
);
  // ***************************************************
  // Input synchronisers
  // ***************************************************
  logic [2:0] pri_s;
  logic [2:0] sec_s;
  logic [2:0] fb_s;
  logic [1:0] mode_s0;
  logic [1:0] mode_s1;
  logic [CFG_W-1:0] pins_s0;
  logic [CFG_W-1:0] pins_s1;
  logic pri_edge;
  logic sec_edge;
  logic fb_edge;

  // Clock-like pins get a third stage so edges are seen cleanly
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      pri_s <= 3'b000;
      sec_s <= 3'b000;
      fb_s <= 3'b000;
      mode_s0 <= 2'b00;
      mode_s1 <= 2'b00;
      pins_s0 <= '0;
      pins_s1 <= '0;
    end else begin
      pri_s <= {pri_s[1:0], primary_reference_input_in};
      sec_s <= {sec_s[1:0], secondary_reference_input_in};
      fb_s <= {fb_s[1:0], fb_clk_in};
      mode_s0 <= si_mode_in;
      mode_s1 <= mode_s0;
      pins_s0 <= standalone_config_pins_in;
      pins_s1 <= pins_s0;
    end
  end
  assign pri_edge = pri_s[1] & ~pri_s[2];
  assign sec_edge = sec_s[1] & ~sec_s[2];
  assign fb_edge = fb_s[1] & ~fb_s[2];

  // ***************************************************
  // Interface mode
  // ***************************************************
  if_mode_e mode;

  // Strap is sampled after release, never under reset
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      mode <= MODE_NONE;
    end else begin
      case (mode_s1)
        SI_SPI: mode <= MODE_SPI; // RULE_13
        SI_I2C: mode <= MODE_I2C; // RULE_13
        SI_PIN: mode <= MODE_PIN; // RULE_13
        default: mode <= MODE_NONE;
      endcase
    end
  end

  // ***************************************************
  // Register file
  // ***************************************************
  logic [REG_W-1:0] regs [REG_COUNT];
  logic [REG_W-1:0] status_word;
  logic ref_sel;
  logic loss_flag;
  logic unlock;

  // Writable bits per register; status sits above the array
  function automatic logic [REG_W-1:0] rw_mask(input logic [4:0] a);
    if (a == REG_ROUTE) begin
      rw_mask = ROUTE_RW_MASK;
    end else if (32'(a) < REG_COUNT) begin
      rw_mask = FULL_RW_MASK;
    end else begin
      rw_mask = '0;
    end
  endfunction

  // Pin mode has no host, so bus writes are dropped there
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= REG_RESET; // RULE_15
      end
    end else if (reg_wr_in && mode != MODE_PIN
                 && 32'(reg_addr_in) < REG_COUNT) begin
      regs[reg_addr_in] <= (regs[reg_addr_in] & ~rw_mask(reg_addr_in))
        | (reg_wdata_in & rw_mask(reg_addr_in)); // RULE_16
    end
  end

  always_comb begin
    status_word = '0;
    status_word[ST_SEL_BIT] = ref_sel;
    status_word[ST_LOS_BIT] = loss_flag;
    status_word[ST_UNLOCK_BIT] = unlock; // RULE_05
  end

  // Read data is one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      if (reg_addr_in == REG_STATUS) begin
        reg_rdata_out <= status_word;
      end else if (32'(reg_addr_in) < REG_COUNT) begin
        reg_rdata_out <= regs[reg_addr_in]; // RULE_15
      end else begin
        reg_rdata_out <= '0;
      end
    end
  end

  // ***************************************************
  // Reference health
  // ***************************************************
  logic [9:0] wd_pri;
  logic [9:0] wd_sec;
  logic lost_pri;
  logic lost_sec;
  logic sec_en;
  logic smart_en;

  // Watchdog: clear on an edge, saturate at the limit
  function automatic logic [9:0] wd_next(input logic [9:0] c,
                                         input logic e);
    if (e) begin
      wd_next = 10'h000;
    end else if (c == 10'(LOS_LIMIT)) begin
      wd_next = c;
    end else begin
      wd_next = c + 10'h001;
    end
  endfunction

  assign lost_pri = (wd_pri == 10'(LOS_LIMIT));
  assign lost_sec = (wd_sec == 10'(LOS_LIMIT));
  assign sec_en = regs[REG_INPUT][IN_SEC_EN_BIT];
  assign smart_en = regs[REG_INPUT][IN_SMART_BIT];

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      wd_pri <= 10'h000;
      wd_sec <= 10'h000;
    end else begin
      wd_pri <= wd_next(wd_pri, pri_edge);
      wd_sec <= wd_next(wd_sec, sec_edge);
    end
  end

  // Smart mux leaves a dead primary only for a live secondary
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      ref_sel <= 1'b0;
    end else if (!smart_en) begin
      ref_sel <= regs[REG_INPUT][IN_MAN_SEL_BIT]; // RULE_02
    end else if (!ref_sel && lost_pri && !lost_sec) begin
      ref_sel <= 1'b1; // RULE_02
    end else if (ref_sel && !lost_pri) begin
      ref_sel <= 1'b0; // RULE_02
    end
  end

  // Both stalled still reads a steady high here
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      loss_flag <= 1'b1;
    end else if (!sec_en) begin
      loss_flag <= 1'b1; // RULE_04
    end else begin
      loss_flag <= ref_sel ? lost_sec : lost_pri; // RULE_03 RULE_12 RULE_17
    end
  end

  slip_lock_detect #(
    .SLIP_MAX(SLIP_LIMIT),
    .HOLD(HOLD)
  ) slip_lock_detect_inst (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .ref_edge_in(ref_sel ? sec_edge : pri_edge),
    .fb_edge_in(fb_edge),
    .unlock_out(unlock)
  );

  // ***************************************************
  // Status pins and configuration outputs
  // ***************************************************
  logic [REG_W-1:0] route;
  assign route = regs[REG_ROUTE];

  // Pins show lock, not unlock, so unlock is inverted here
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      health_output_a_out <= 1'b0;
      health_output_b_out <= 1'b0;
    end else begin
      health_output_a_out <= (route[ROUTE_A_SEL] & ref_sel)
        | (route[ROUTE_A_LOS] & loss_flag)
        | (route[ROUTE_A_UNL] & ~unlock); // RULE_01 RULE_05 RULE_06
      health_output_b_out <= (route[ROUTE_B_SEL] & ref_sel)
        | (route[ROUTE_B_LOS] & loss_flag)
        | (route[ROUTE_B_UNL] & ~unlock); // RULE_01 RULE_05 RULE_06
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      spi_en_out <= 1'b0;
      i2c_en_out <= 1'b0;
      cfg_select_out <= '0;
    end else begin
      spi_en_out <= (mode == MODE_SPI); // RULE_13
      i2c_en_out <= (mode == MODE_I2C); // RULE_13
      cfg_select_out <= (mode == MODE_PIN) ? pins_s1
        : regs[REG_CFG][CFG_W-1:0]; // RULE_14
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  // Any enabled flag that is active must pull the pin high
  a_route_a_or: assert property (@(posedge core_clk_in) // RULE_06
    disable iff (!rst_b_in)
    ((route[ROUTE_A_SEL] && ref_sel) || (route[ROUTE_A_LOS] && loss_flag)
      || (route[ROUTE_A_UNL] && !unlock)) |=> health_output_a_out)
    else $error("status output a wrong");
  a_route_a_off: assert property (@(posedge core_clk_in) // RULE_01
    disable iff (!rst_b_in)
    route[ROUTE_A_SEL:ROUTE_A_UNL] == 3'b000 |=> !health_output_a_out)
    else $error("status output a high with no enable");
  a_route_b_unl: assert property (@(posedge core_clk_in) // RULE_05
    disable iff (!rst_b_in)
    (route[ROUTE_A_SEL:ROUTE_B_UNL] == 6'b000001 && unlock)
    |=> !health_output_b_out)
    else $error("status output b not low on unlock");
  a_los_forced: assert property (@(posedge core_clk_in) // RULE_04
    disable iff (!rst_b_in) !sec_en ##1 !sec_en |-> loss_flag)
    else $error("loss flag not forced high");
  a_los_active: assert property (@(posedge core_clk_in) // RULE_03
    disable iff (!rst_b_in) (sec_en && !ref_sel && lost_pri) |=> loss_flag)
    else $error("loss flag missed lost primary");
  a_ro_route: assert property (@(posedge core_clk_in) // RULE_16
    disable iff (!rst_b_in)
    (reg_wr_in && reg_addr_in == REG_ROUTE && mode != MODE_PIN)
    |=> (route & ~ROUTE_RW_MASK) == 16'h0000
        && route[12:7] == $past(reg_wdata_in[12:7]))
    else $error("route register write wrong");
  a_status_read: assert property (@(posedge core_clk_in) // RULE_05
    disable iff (!rst_b_in)
    (reg_rd_in && reg_addr_in == REG_STATUS)
    |=> reg_rdata_out[ST_UNLOCK_BIT] == $past(unlock))
    else $error("status unlock bit wrong");
  a_pin_cfg: assert property (@(posedge core_clk_in) // RULE_14
    disable iff (!rst_b_in)
    mode == MODE_PIN |=> cfg_select_out == $past(pins_s1))
    else $error("pin mode config not from pins");
  a_pin_nowrite: assert property (@(posedge core_clk_in) // RULE_13
    disable iff (!rst_b_in)
    (mode == MODE_PIN && reg_wr_in) |=> $stable(route))
    else $error("write accepted in pin mode");
  a_manual_sel: assert property (@(posedge core_clk_in) // RULE_02
    disable iff (!rst_b_in)
    !smart_en |=> ref_sel == $past(regs[REG_INPUT][IN_MAN_SEL_BIT]))
    else $error("manual select not followed");
  c_smart_switch: cover property (@(posedge core_clk_in)
    disable iff (!rst_b_in) smart_en && $rose(ref_sel));
  c_unlock_pin: cover property (@(posedge core_clk_in)
    disable iff (!rst_b_in) route[ROUTE_A_UNL] && $fell(health_output_a_out));
  c_pin_mode: cover property (@(posedge core_clk_in)
    disable iff (!rst_b_in) mode == MODE_PIN);
endmodule
`default_nettype wire

// >>> ref_clock_source.sv
// Reference and feedback clock sources seen by the health status block
`timescale 1ns/100ps
`default_nettype none
module ref_clock_source #(
  parameter int HALF = 2
) (
  input wire logic core_clk_in,
  input wire logic pri_run_in,
  input wire logic sec_run_in,
  input wire logic fb_run_in,
  output var logic pri_clk_out,
  output var logic sec_clk_out,
  output var logic fb_clk_out
);
  logic [7:0] tick_cnt;
  logic tick;

  initial begin
    tick_cnt = 8'h00;
    pri_clk_out = 1'b0;
    sec_clk_out = 1'b0;
    fb_clk_out = 1'b0;
  end

  // One shared tick keeps all three sources in phase, so feedback and
  // reference agree until one of them is stopped
  assign tick = (tick_cnt == 8'(HALF - 1));

  // A stopped source parks low, as a dead oscillator would
  always @(posedge core_clk_in) begin
    tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
    pri_clk_out <= pri_run_in & (pri_clk_out ^ tick);
    sec_clk_out <= sec_run_in & (sec_clk_out ^ tick);
    fb_clk_out <= fb_run_in & (fb_clk_out ^ tick);
  end
endmodule
`default_nettype wire

// >>> status_pin_mux_lock_detect_test.sv
// Self-checking bench for status routing, flags and register file
`timescale 1ns/100ps
`default_nettype none
module status_pin_mux_lock_detect_test;
  import health_status_pkg::*;
  typedef struct packed {logic [2:0] src; logic [15:0] val;} note_s;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic pri, sec, fb;
  logic pri_run = 1'b1, sec_run = 1'b1, fb_run = 1'b1;
  logic [1:0] si_mode = 2'b00;
  logic [4:0] cfg_pins = 5'h00;
  logic [4:0] reg_addr = 5'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0, obs = 1'b0;
  logic [15:0] reg_wdata = 16'h0000, rdata, d;
  logic pin_a, pin_b, spi_en, i2c_en;
  logic [4:0] cfg_sel;
  note_s notes[$];
  int failures = 0, num_checks = 0, seed = 19677, i;

  always #4 core_clk = ~core_clk;

  health_status_top #(.LOS_LIMIT(8), .HOLD(16)) health_status_top_inst (
    .core_clk_in(core_clk), .rst_b_in(rst_b),
    .primary_reference_input_in(pri), .secondary_reference_input_in(sec),
    .fb_clk_in(fb), .si_mode_in(si_mode),
    .standalone_config_pins_in(cfg_pins), .reg_addr_in(reg_addr),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata),
    .reg_rdata_out(rdata), .health_output_a_out(pin_a),
    .health_output_b_out(pin_b), .spi_en_out(spi_en),
    .i2c_en_out(i2c_en), .cfg_select_out(cfg_sel));

  ref_clock_source ref_clock_source_inst (
    .core_clk_in(core_clk), .pri_run_in(pri_run), .sec_run_in(sec_run),
    .fb_run_in(fb_run), .pri_clk_out(pri), .sec_clk_out(sec),
    .fb_clk_out(fb));

  // ***********************************
  // Comparison and closing report
  // ***********************************
  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task test_done;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function logic [15:0] observed(input logic [2:0] src);
    case (src)
      3'd1: observed = {15'h0000, pin_a};
      3'd2: observed = {15'h0000, pin_b};
      3'd3: observed = {15'h0000, spi_en};
      3'd4: observed = {15'h0000, i2c_en};
      3'd5: observed = {11'h000, cfg_sel};
      default: observed = rdata;
    endcase
  endfunction

  // Watcher: read data lands one cycle after the strobe, so the oldest
  // note is compared on the edge at which rd_d or obs is seen high
  always @(posedge core_clk) begin
    rd_d <= reg_rd;
    if ((rd_d || obs) && notes.size() > 0) begin
      check(observed(notes[0].src), notes[0].val);
      notes.pop_front();
    end
  end

  // ***********************************
  // Register port and observation tasks
  // ***********************************
  task wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    notes.push_back({3'd0, e});
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask

  task see(input logic [2:0] s, input logic [15:0] e);
    @(posedge core_clk);
    obs <= 1'b1;
    notes.push_back({s, e});
    @(posedge core_clk);
    obs <= 1'b0;
  endtask

  task settle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Bounded wait; running out counts as a mismatch and ends the run
  task wait_pin_a(input logic lvl);
    for (int k = 0; k < 200 && pin_a !== lvl; k++) @(posedge core_clk);
    if (pin_a !== lvl) begin
      failures++;
      test_done();
    end
  endtask

  // ***********************************
  // Main sequence
  // ***********************************
  initial begin
    settle(20);
    rst_b <= 1'b1;
    settle(3);
    // Secondary enable still clear, so loss must read high
    wr(REG_ROUTE, 16'h0100);
    settle(6);
    see(3'd2, 16'h0001);
    rd(REG_STATUS, 16'h0002);
    wr(REG_INPUT, 16'h0020);
    settle(40);
    rd(REG_STATUS, 16'h0000);
    // Random routing words: only the six enables may stick
    for (i = 0; i < 4; i++) begin
      d = 16'($random(seed));
      wr(REG_ROUTE, d);
      rd(REG_ROUTE, d & ROUTE_RW_MASK);
    end
    d = 16'($random(seed));
    wr(5'd20, d);
    rd(5'd20, d);
    wr(REG_STATUS, 16'hffff);
    rd(REG_STATUS, 16'h0000);
    rd(5'd22, 16'h0000);
    // One enable at a time; only the lock level reads high
    for (i = 0; i < 6; i++) begin
      wr(REG_ROUTE, 16'(1 << (7 + i)));
      settle(4);
      see((i < 3) ? 3'd2 : 3'd1, 16'(i == 0 || i == 3));
    end
    wr(REG_INPUT, 16'h0021);
    settle(10);
    rd(REG_STATUS, 16'h0001);
    wr(REG_INPUT, 16'h0020);
    // Pin a ORs loss and lock, pin b shows loss alone
    wr(REG_ROUTE, 16'h0d00);
    settle(10);
    see(3'd1, 16'h0001);
    fb_run <= 1'b0;
    wait_pin_a(1'b0);
    see(3'd1, 16'h0000);
    rd(REG_STATUS, 16'h0004);
    // Unlock alone on pin b drives it low while unlocked
    wr(REG_ROUTE, 16'h0080);
    settle(3);
    see(3'd2, 16'h0000);
    wr(REG_ROUTE, 16'h0d00);
    pri_run <= 1'b0;
    settle(40);
    see(3'd1, 16'h0001);
    see(3'd2, 16'h0001);
    pri_run <= 1'b1;
    fb_run <= 1'b1;
    settle(60);
    see(3'd1, 16'h0001);
    see(3'd2, 16'h0000);
    // Smart mux: a dead primary hands over to a live secondary
    wr(REG_ROUTE, 16'h1100);
    wr(REG_INPUT, 16'h0022);
    pri_run <= 1'b0;
    settle(30);
    see(3'd1, 16'h0001);
    see(3'd2, 16'h0000);
    // Both references stalled: loss must read high
    sec_run <= 1'b0;
    settle(30);
    see(3'd1, 16'h0001);
    see(3'd2, 16'h0001);
    pri_run <= 1'b1;
    sec_run <= 1'b1;
    settle(30);
    see(3'd1, 16'h0000);
    see(3'd2, 16'h0000);
    wr(REG_INPUT, 16'h0020);
    // Every strap code; pin mode takes config from the pins
    for (i = 0; i < 4; i++) begin
      si_mode <= 2'(i);
      cfg_pins <= 5'($random(seed));
      settle(6);
      see(3'd3, 16'(i == 0));
      see(3'd4, 16'(i == 1));
      if (i == 2) begin
        see(3'd5, {11'h000, cfg_pins});
        wr(REG_CFG, 16'h0013);
      end
    end
    si_mode <= 2'b00;
    settle(6);
    see(3'd5, 16'h0000);
    wr(REG_CFG, 16'h0013);
    settle(3);
    see(3'd5, 16'h0013);
    settle(4);
    test_done();
  end
endmodule
`default_nettype wire
